// File: shared/ocs_pkg.sv
// package: register map, field positions, mode and selector codes for the compare channel
// Notes on behaviour
// - trigger clear mode: secondary match or software clears
// - mode 111: high on primary, low secondary
// - mode 110: high at zero, low primary
// - mode 101: start low, toggle alternating matches
// - mode 100: start low, one pulse only
// - mode 011: toggle on every primary match
// - mode 010: start high, low on primary
// - mode 001: start low, high on primary
// - mode 000 disables channel; three-bit field
// - compare values double-buffered only in pwm modes
// - selector 11111 syncs on own secondary match
// - 11110..11000: int pins, charge unit, adc, comparators
// - 10011..10000: input capture events four to one
// - 01111..01011 timers; timer two is reset default
// - 01010 selects trigger generator output
// - 00100..00001 select compare channels four to one
// - 00000: no source, channel free-runs
// - trigger-out pulse when channel switched off
`default_nettype none
package ocs_pkg;
	// ----------------------------------------
	// register byte addresses
	// ----------------------------------------
	localparam logic [11:0] OCS_ADDR_CTRL_ONE = 12'h000;
	localparam logic [11:0] OCS_ADDR_CTRL_TWO = 12'h004;
	localparam logic [11:0] OCS_ADDR_PRIMARY  = 12'h008;
	localparam logic [11:0] OCS_ADDR_SECOND   = 12'h00C;
	localparam logic [11:0] OCS_ADDR_COUNT    = 12'h010;
	// ----------------------------------------
	// field positions and reset values
	// ----------------------------------------
	localparam int          OCS_MODE_LSB      = 0;
	localparam int          OCS_TRIG_MODE_BIT = 3;
	localparam int          OCS_SYNC_LSB      = 0;
	localparam int          OCS_TRIG_STAT_BIT = 6;
	localparam int          OCS_TRIG_EN_BIT   = 7;
	localparam logic [4:0]  OCS_SYNC_RESET    = 5'h0C;
	localparam logic [15:0] OCS_VALUE_RESET   = 16'h0000;
	// ----------------------------------------
	// mode codes
	// ----------------------------------------
	localparam logic [2:0] OCS_MODE_OFF    = 3'h0;
	localparam logic [2:0] OCS_MODE_SS_HI  = 3'h1;
	localparam logic [2:0] OCS_MODE_SS_LO  = 3'h2;
	localparam logic [2:0] OCS_MODE_TOGGLE = 3'h3;
	localparam logic [2:0] OCS_MODE_DBL_SS = 3'h4;
	localparam logic [2:0] OCS_MODE_DBL_CP = 3'h5;
	localparam logic [2:0] OCS_MODE_EPWM   = 3'h6;
	localparam logic [2:0] OCS_MODE_CPWM   = 3'h7;
	// ----------------------------------------
	// source selector codes
	// ----------------------------------------
	localparam logic [4:0] OCS_SEL_NONE    = 5'h00;
	localparam logic [4:0] OCS_SEL_OC_LO   = 5'h01;
	localparam logic [4:0] OCS_SEL_OC_HI   = 5'h04;
	localparam logic [4:0] OCS_SEL_TRIGGEN = 5'h0A;
	localparam logic [4:0] OCS_SEL_TMR_LO  = 5'h0B;
	localparam logic [4:0] OCS_SEL_TMR_HI  = 5'h0F;
	localparam logic [4:0] OCS_SEL_IC_LO   = 5'h10;
	localparam logic [4:0] OCS_SEL_IC_HI   = 5'h13;
	localparam logic [4:0] OCS_SEL_CMP_LO  = 5'h18;
	localparam logic [4:0] OCS_SEL_CMP_HI  = 5'h1A;
	localparam logic [4:0] OCS_SEL_ADC     = 5'h1B;
	localparam logic [4:0] OCS_SEL_CHARGE  = 5'h1C;
	localparam logic [4:0] OCS_SEL_INT_ONE = 5'h1D;
	localparam logic [4:0] OCS_SEL_INT_TWO = 5'h1E;
	localparam logic [4:0] OCS_SEL_SELF    = 5'h1F;
	// ----------------------------------------
	// output state machine
	// ----------------------------------------
	typedef enum logic [2:0] {
		OCS_ST_IDLE   = 3'b001,
		OCS_ST_FIRST  = 3'b010,
		OCS_ST_SECOND = 3'b100
	} ocs_state_type;
endpackage
`default_nettype wire

// File: rtl/ocs_source_mux.sv
// selector of the synchronization or trigger source event
`default_nettype none
module ocs_source_mux
	import ocs_pkg::*;
(
	input  wire logic [4:0] sel,
	input  wire logic       self_match,
	input  wire logic [3:0] oc_events,
	input  wire logic       trig_gen_event,
	input  wire logic [4:0] timer_events,
	input  wire logic [3:0] capture_events,
	input  wire logic [2:0] comparator_events,
	input  wire logic       adc_event,
	input  wire logic       charge_event,
	input  wire logic       int_pin_one,
	input  wire logic       int_pin_two,
	output logic            source_valid,
	output logic            source_event
);
	always_comb begin
		source_valid = 1'b1;
		source_event = 1'b0;
		if (sel == OCS_SEL_SELF) begin
			source_event = self_match;
		end else if (sel == OCS_SEL_INT_TWO) begin
			source_event = int_pin_two;
		end else if (sel == OCS_SEL_INT_ONE) begin
			source_event = int_pin_one;
		end else if (sel == OCS_SEL_CHARGE) begin
			source_event = charge_event;
		end else if (sel == OCS_SEL_ADC) begin
			source_event = adc_event;
		end else if (sel >= OCS_SEL_CMP_LO && sel <= OCS_SEL_CMP_HI) begin
			source_event = comparator_events[2'(sel - OCS_SEL_CMP_LO)];
		end else if (sel >= OCS_SEL_IC_LO && sel <= OCS_SEL_IC_HI) begin
			source_event = capture_events[2'(sel - OCS_SEL_IC_LO)];
		end else if (sel >= OCS_SEL_TMR_LO && sel <= OCS_SEL_TMR_HI) begin
			source_event = timer_events[3'(sel - OCS_SEL_TMR_LO)];
		end else if (sel == OCS_SEL_TRIGGEN) begin
			source_event = trig_gen_event;
		end else if (sel >= OCS_SEL_OC_LO && sel <= OCS_SEL_OC_HI) begin
			source_event = oc_events[2'(sel - OCS_SEL_OC_LO)];
		end else begin
			// none and reserved codes: free-run
			source_valid = 1'b0;
		end
	end
endmodule // ocs_source_mux
`default_nettype wire

// File: rtl/ocs_compare_channel.sv
// output compare channel with apb registers, timebase, modes and source selection
//
// Added by the designer: the register addresses and the APB slave port.
`default_nettype none
module ocs_compare_channel
	import ocs_pkg::*;
#(
	parameter int COUNT_WIDTH = 16
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        timer_clock_tick,
	input  wire logic [3:0]  oc_events,
	input  wire logic        trig_gen_event,
	input  wire logic [4:0]  timer_events,
	input  wire logic [3:0]  capture_events,
	input  wire logic [2:0]  comparator_events,
	input  wire logic        adc_event,
	input  wire logic        charge_event,
	input  wire logic        int_pin_one,
	input  wire logic        int_pin_two,
	output logic             compare_output,
	output logic             trigger_out
);
	// wider counts would not fit the 16-bit value fields on the bus
	if (COUNT_WIDTH < 2 || COUNT_WIDTH > 16) begin : g_width_check
		$error("COUNT_WIDTH must be 2 to 16");
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [3:0]             ctrl_one_reg;
	logic [4:0]             sync_sel_reg;
	logic                   trig_en_reg;
	logic                   trigger_status_reg;
	logic [COUNT_WIDTH-1:0] primary_buf_reg;
	logic [COUNT_WIDTH-1:0] second_buf_reg;
	logic [COUNT_WIDTH-1:0] primary_act_reg;
	logic [COUNT_WIDTH-1:0] second_act_reg;
	logic [COUNT_WIDTH-1:0] count_reg;
	logic [COUNT_WIDTH-1:0] count_next;
	ocs_state_type          state_reg;
	logic                   out_reg;
	logic                   trig_out_reg;

	logic [2:0]             mode;
	logic                   trig_mode;
	logic                   is_pwm;
	logic                   wr;
	logic                   primary_match;
	logic                   second_match;
	logic                   zero_match;
	logic                   source_valid;
	logic                   source_event;
	logic                   sw_clear;
	logic                   hw_clear;
	logic                   period_end;

	assign mode      = ctrl_one_reg[OCS_MODE_LSB +: 3];
	assign trig_mode = ctrl_one_reg[OCS_TRIG_MODE_BIT];
	assign is_pwm    = (mode == OCS_MODE_EPWM) || (mode == OCS_MODE_CPWM);

	// ----------------------------------------
	// apb slave: zero wait states
	// ----------------------------------------
	assign pready    = 1'b1;
	assign wr        = psel && penable && pwrite;
	assign pslverr   = psel && penable && !(paddr == OCS_ADDR_CTRL_ONE ||
		paddr == OCS_ADDR_CTRL_TWO || paddr == OCS_ADDR_PRIMARY ||
		paddr == OCS_ADDR_SECOND || paddr == OCS_ADDR_COUNT);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			case (paddr)
				OCS_ADDR_CTRL_ONE: prdata <= {28'h000_0000, ctrl_one_reg};
				OCS_ADDR_CTRL_TWO: prdata <= {24'h00_0000, trig_en_reg,
					trigger_status_reg, 1'b0, sync_sel_reg};
				OCS_ADDR_PRIMARY: prdata <= 32'(primary_buf_reg);
				OCS_ADDR_SECOND:  prdata <= 32'(second_buf_reg);
				OCS_ADDR_COUNT:   prdata <= 32'(count_reg);
				default:          prdata <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_one_reg <= 4'h0;
			sync_sel_reg <= OCS_SYNC_RESET;
			trig_en_reg  <= 1'b0;
		end else if (wr && paddr == OCS_ADDR_CTRL_ONE) begin
			ctrl_one_reg <= pwdata[3:0];
		end else if (wr && paddr == OCS_ADDR_CTRL_TWO) begin
			sync_sel_reg <= pwdata[OCS_SYNC_LSB +: 5];
			trig_en_reg  <= pwdata[OCS_TRIG_EN_BIT];
		end
	end

	// ----------------------------------------
	// compare values: buffered only in pwm
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			primary_buf_reg <= COUNT_WIDTH'(OCS_VALUE_RESET);
			second_buf_reg  <= COUNT_WIDTH'(OCS_VALUE_RESET);
		end else if (wr && paddr == OCS_ADDR_PRIMARY) begin
			primary_buf_reg <= pwdata[COUNT_WIDTH-1:0];
		end else if (wr && paddr == OCS_ADDR_SECOND) begin
			second_buf_reg <= pwdata[COUNT_WIDTH-1:0];
		end
	end

	// active copy loads at period end in pwm, follows the buffer otherwise
	assign period_end = timer_clock_tick && (count_next == '0);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			primary_act_reg <= COUNT_WIDTH'(OCS_VALUE_RESET);
			second_act_reg  <= COUNT_WIDTH'(OCS_VALUE_RESET);
		end else if (!is_pwm || period_end) begin
			primary_act_reg <= primary_buf_reg;
			second_act_reg  <= second_buf_reg;
		end
	end

	// ----------------------------------------
	// timebase count
	// ----------------------------------------
	assign primary_match = timer_clock_tick && (count_reg == primary_act_reg);
	assign second_match  = timer_clock_tick && (count_reg == second_act_reg);
	assign zero_match    = timer_clock_tick && (count_reg == '0);

	ocs_source_mux ocs_source_mux_inst (
		.sel               (sync_sel_reg),
		.self_match        (second_match),
		.oc_events         (oc_events),
		.trig_gen_event    (trig_gen_event),
		.timer_events      (timer_events),
		.capture_events    (capture_events),
		.comparator_events (comparator_events),
		.adc_event         (adc_event),
		.charge_event      (charge_event),
		.int_pin_one       (int_pin_one),
		.int_pin_two       (int_pin_two),
		.source_valid      (source_valid),
		.source_event      (source_event)
	);

	// sync clear wins over counting so the period restarts at zero
	always_comb begin
		count_next = count_reg;
		if (mode == OCS_MODE_OFF) begin
			count_next = '0;
		end else if (source_valid && source_event) begin
			count_next = '0;
		end else if (timer_clock_tick) begin
			count_next = count_reg + 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_reg <= '0;
		end else begin
			count_reg <= count_next;
		end
	end

	// ----------------------------------------
	// trigger status
	// ----------------------------------------
	assign sw_clear = wr && paddr == OCS_ADDR_CTRL_TWO && !pwdata[OCS_TRIG_STAT_BIT];
	assign hw_clear = trig_mode && second_match;

	// a source event on the clearing cycle still sets the flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trigger_status_reg <= 1'b0;
		end else if (trig_en_reg && source_valid && source_event) begin
			trigger_status_reg <= 1'b1;
		end else if (sw_clear || hw_clear) begin
			trigger_status_reg <= 1'b0;
		end
	end

	// ----------------------------------------
	// output modes
	// ----------------------------------------
	logic [2:0] mode_prev_reg;
	logic       mode_changed;
	assign mode_changed = mode != mode_prev_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_prev_reg <= OCS_MODE_OFF;
		end else begin
			mode_prev_reg <= mode;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_reg   <= 1'b0;
			state_reg <= OCS_ST_IDLE;
		end else if (mode_changed) begin
			out_reg   <= (mode == OCS_MODE_SS_LO);
			state_reg <= OCS_ST_FIRST;
		end else begin
			case (mode)
				OCS_MODE_OFF: begin
					out_reg   <= 1'b0;
					state_reg <= OCS_ST_IDLE;
				end
				OCS_MODE_SS_HI: if (primary_match) begin
					out_reg <= 1'b1;
				end
				OCS_MODE_SS_LO: if (primary_match) begin
					out_reg <= 1'b0;
				end
				OCS_MODE_TOGGLE: if (primary_match) begin
					out_reg <= !out_reg;
				end
				OCS_MODE_DBL_SS, OCS_MODE_DBL_CP: begin
					case (state_reg)
						OCS_ST_FIRST: if (primary_match) begin
							out_reg   <= 1'b1;
							state_reg <= OCS_ST_SECOND;
						end
						OCS_ST_SECOND: if (second_match) begin
							out_reg   <= 1'b0;
							state_reg <= (mode == OCS_MODE_DBL_CP) ? OCS_ST_FIRST
								: OCS_ST_IDLE;
						end
						default: state_reg <= state_reg;
					endcase
				end
				OCS_MODE_EPWM: begin
					if (primary_match) begin
						out_reg <= 1'b0;
					end else if (zero_match) begin
						out_reg <= 1'b1;
					end
				end
				OCS_MODE_CPWM: begin
					if (second_match) begin
						out_reg <= 1'b0;
					end else if (primary_match) begin
						out_reg <= 1'b1;
					end
				end
				default: out_reg <= out_reg;
			endcase
		end
	end

	assign compare_output = out_reg;

	// ----------------------------------------
	// trigger out: primary matches plus switch-off
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trig_out_reg <= 1'b0;
		end else begin
			trig_out_reg <= (mode_changed && mode == OCS_MODE_OFF) ||
				(mode != OCS_MODE_OFF && primary_match);
		end
	end

	assign trigger_out = trig_out_reg;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	property p_off_low;
		@(posedge pclk) disable iff (!presetn)
		(mode == OCS_MODE_OFF && !mode_changed) |=> !compare_output;
	endproperty
	a_off_low: assert property (p_off_low) else $error("output high while off");

	property p_epwm_fall;
		@(posedge pclk) disable iff (!presetn)
		(mode == OCS_MODE_EPWM && !mode_changed && primary_match) |=> !compare_output;
	endproperty
	a_epwm_fall: assert property (p_epwm_fall) else $error("pwm edge missed");

	property p_cpwm_rise;
		@(posedge pclk) disable iff (!presetn)
		(mode == OCS_MODE_CPWM && !mode_changed && primary_match && !second_match)
			|=> compare_output;
	endproperty
	a_cpwm_rise: assert property (p_cpwm_rise) else $error("centre rise missed");

	property p_toggle;
		@(posedge pclk) disable iff (!presetn)
		(mode == OCS_MODE_TOGGLE && !mode_changed && primary_match)
			|=> compare_output != $past(compare_output);
	endproperty
	a_toggle: assert property (p_toggle) else $error("toggle missed");

	property p_ss_hi;
		@(posedge pclk) disable iff (!presetn)
		(mode == OCS_MODE_SS_HI && !mode_changed && primary_match) |=> compare_output;
	endproperty
	a_ss_hi: assert property (p_ss_hi) else $error("single shot high missed");

	property p_ss_lo_start;
		@(posedge pclk) disable iff (!presetn)
		(mode_changed && mode == OCS_MODE_SS_LO) |=> compare_output;
	endproperty
	a_ss_lo_start: assert property (p_ss_lo_start) else $error("start not high");

	property p_hw_clear;
		@(posedge pclk) disable iff (!presetn)
		(trig_mode && second_match && !(trig_en_reg && source_valid && source_event))
			|=> !trigger_status_reg;
	endproperty
	a_hw_clear: assert property (p_hw_clear) else $error("status not cleared");

	property p_off_pulse;
		@(posedge pclk) disable iff (!presetn)
		(mode_changed && mode == OCS_MODE_OFF) |=> trigger_out ##1 !trigger_out;
	endproperty
	a_off_pulse: assert property (p_off_pulse) else $error("no switch-off pulse");

	property p_direct_load;
		@(posedge pclk) disable iff (!presetn)
		(!is_pwm && wr && paddr == OCS_ADDR_PRIMARY) |=> ##1
			(primary_act_reg == $past(pwdata[COUNT_WIDTH-1:0], 2));
	endproperty
	a_direct_load: assert property (p_direct_load) else $error("direct load late");

	property p_sync_clear;
		@(posedge pclk) disable iff (!presetn)
		(mode != OCS_MODE_OFF && source_valid && source_event) |=> count_reg == '0;
	endproperty
	a_sync_clear: assert property (p_sync_clear) else $error("sync did not clear");
endmodule // ocs_compare_channel
`default_nettype wire

// File: test/ocs_source_model.sv
// model of the timers and trigger sources that feed the compare channel
`default_nettype none
module ocs_source_model
	import ocs_pkg::*;
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       tick_req,
	input  wire logic       fire_stb,
	input  wire logic [4:0] fire_code,
	output logic            timer_clock_tick,
	output logic [3:0]      oc_events,
	output logic            trig_gen_event,
	output logic [4:0]      timer_events,
	output logic [3:0]      capture_events,
	output logic [2:0]      comparator_events,
	output logic            adc_event,
	output logic            charge_event,
	output logic            int_pin_one,
	output logic            int_pin_two
);
	timeunit 1ns;
	timeprecision 1ps;
	logic all_lines;
	// ----------------------------------------
	// event decode
	// ----------------------------------------
	// empty and reserved codes pulse every line, so a wrong pick shows as a cleared count
	assign all_lines = fire_code inside {5'h00, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09,
		5'h14, 5'h15, 5'h16, 5'h17};
	function automatic logic hit(input logic [4:0] c);
		return fire_stb && (all_lines || fire_code == c);
	endfunction
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{timer_clock_tick, oc_events, trig_gen_event, timer_events} <= '0;
			{capture_events, comparator_events, adc_event, charge_event} <= '0;
			{int_pin_one, int_pin_two} <= '0;
		end else begin
			timer_clock_tick <= tick_req;
			for (int i = 0; i < 5; i++) begin
				timer_events[i] <= hit(5'h0B + 5'(i));
				if (i < 4) begin
					// lines of other channels only: the channel itself is never offered
					oc_events[i] <= hit(5'h01 + 5'(i));
					capture_events[i] <= hit(5'h10 + 5'(i));
				end
				if (i < 3) begin
					comparator_events[i] <= hit(5'h18 + 5'(i));
				end
			end
			trig_gen_event <= hit(5'h0A);
			adc_event <= hit(5'h1B);
			charge_event <= hit(5'h1C);
			int_pin_one <= hit(5'h1D);
			int_pin_two <= hit(5'h1E);
		end
	end
endmodule // ocs_source_model
`default_nettype wire

// File: test/ocs_compare_channel_tb.sv
// self-checking testbench of the compare channel
`default_nettype none
module ocs_compare_channel_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import ocs_pkg::*;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        tick_req = 1'b0;
	logic        fire_stb = 1'b0;
	logic [4:0]  fire_code = 5'h00;
	logic        tick;
	logic [3:0]  oc_ev;
	logic        tg_ev;
	logic [4:0]  tm_ev;
	logic [3:0]  ic_ev;
	logic [2:0]  cm_ev;
	logic        adc_ev;
	logic        chg_ev;
	logic        int_one;
	logic        int_two;
	logic        compare_output;
	logic        trigger_out;
	int          errors = 0;
	int          samples_checked = 0;
	int          trig_pulses = 0;
	int          n0;
	logic [31:0] exp_cnt;
	logic [2:0]  modes [3] = '{3'h1, 3'h2, 3'h3};
	logic        init_lvl [3] = '{1'b0, 1'b1, 1'b0};

	always #10 pclk = ~pclk;
	always @(posedge pclk) begin
		if (trigger_out === 1'b1) begin
			trig_pulses <= trig_pulses + 1;
		end
	end

	ocs_compare_channel ocs_compare_channel_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .timer_clock_tick(tick), .oc_events(oc_ev),
		.trig_gen_event(tg_ev), .timer_events(tm_ev), .capture_events(ic_ev),
		.comparator_events(cm_ev), .adc_event(adc_ev), .charge_event(chg_ev),
		.int_pin_one(int_one), .int_pin_two(int_two), .compare_output(compare_output),
		.trigger_out(trigger_out));
	ocs_source_model ocs_source_model_inst (.pclk(pclk), .presetn(presetn), .tick_req(tick_req),
		.fire_stb(fire_stb), .fire_code(fire_code), .timer_clock_tick(tick), .oc_events(oc_ev),
		.trig_gen_event(tg_ev), .timer_events(tm_ev), .capture_events(ic_ev),
		.comparator_events(cm_ev), .adc_event(adc_ev), .charge_event(chg_ev),
		.int_pin_one(int_one), .int_pin_two(int_two));

	// ----------------------------------------
	// bus and check tasks
	// ----------------------------------------
	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic check(input string name, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			errors++;
			$display("wrong value %s expected %h seen %h", name, e, g);
		end
	endtask
	// idle edge at the end keeps back-to-back calls from driving psel twice in one step
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic er);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 16) begin
			n++;
			@(posedge pclk);
		end
		if (n == 16) begin
			errors++;
			close_out();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic        er;
		apb(1'b1, a, d, rd, er);
	endtask
	task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] m,
		input logic [31:0] e);
		logic [31:0] rd;
		logic        er;
		apb(1'b0, a, 32'h0000_0000, rd, er);
		check(nm, e, rd & m);
	endtask
	task automatic chk_out(input logic e);
		check("compare_output", {31'h0, e}, {31'h0, compare_output});
	endtask
	task automatic ticks(input int n);
		tick_req <= 1'b1;
		repeat (n) @(posedge pclk);
		tick_req <= 1'b0;
		repeat (4) @(posedge pclk);
	endtask
	task automatic fire(input logic [4:0] c);
		fire_code <= c;
		fire_stb <= 1'b1;
		@(posedge pclk);
		fire_stb <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask
	task automatic set_mode(input logic [31:0] m);
		wr(OCS_ADDR_CTRL_ONE, m);
		repeat (2) @(posedge pclk);
	endtask
	function automatic logic src_valid(input int c);
		return (c >= 1 && c <= 4) || (c >= 10 && c <= 19) || (c >= 24 && c <= 30);
	endfunction

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		logic [31:0] rd;
		logic        er;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdc("ctrl_one", OCS_ADDR_CTRL_ONE, 32'h0000_000F, 32'h0000_0000);
		rdc("sync_sel", OCS_ADDR_CTRL_TWO, 32'h0000_001F, 32'h0000_000C);
		apb(1'b0, 12'h020, 32'h0000_0000, rd, er);
		check("unmapped", 32'h0000_0001, {rd[30:0], er});
		wr(OCS_ADDR_COUNT, 32'h0000_1234);
		rdc("count", OCS_ADDR_COUNT, 32'h0000_FFFF, 32'h0000_0000);
		$display("test registers done");
		// single compare modes, then switch off
		wr(OCS_ADDR_CTRL_TWO, 32'h0000_0000);
		wr(OCS_ADDR_PRIMARY, 32'h0000_0005);
		for (int i = 0; i < 3; i++) begin
			set_mode({29'h0, modes[i]});
			chk_out(init_lvl[i]);
			ticks(5);
			chk_out(init_lvl[i]);
			ticks(1);
			chk_out(!init_lvl[i]);
			n0 = trig_pulses;
			set_mode(32'h0000_0000);
			check("trigger_out", 32'(n0 + 1), 32'(trig_pulses));
		end
		ticks(6);
		chk_out(1'b0);
		$display("test single modes done");
		wr(OCS_ADDR_PRIMARY, 32'h0000_0003);
		wr(OCS_ADDR_SECOND, 32'h0000_0006);
		for (int m = 4; m < 6; m++) begin
			set_mode(32'(m));
			chk_out(1'b0);
			ticks(4);
			chk_out(1'b1);
			ticks(3);
			chk_out(1'b0);
			set_mode(32'h0000_0000);
		end
		$display("test double modes done");
		// edge pwm: a primary write mid-period must wait for the wrap
		wr(OCS_ADDR_PRIMARY, 32'h0000_0004);
		set_mode({29'h0, OCS_MODE_EPWM});
		ticks(1);
		chk_out(1'b1);
		wr(OCS_ADDR_PRIMARY, 32'h0000_0002);
		ticks(2);
		chk_out(1'b1);
		rdc("primary", OCS_ADDR_PRIMARY, 32'h0000_FFFF, 32'h0000_0002);
		ticks(2);
		chk_out(1'b0);
		set_mode(32'h0000_0000);
		set_mode({29'h0, OCS_MODE_CPWM});
		chk_out(1'b0);
		ticks(3);
		chk_out(1'b1);
		ticks(4);
		chk_out(1'b0);
		set_mode(32'h0000_0000);
		$display("test pwm done");
		// trigger status with both clear modes, timer one as source
		wr(OCS_ADDR_PRIMARY, 32'h0000_0064);
		wr(OCS_ADDR_CTRL_TWO, 32'h0000_008B);
		set_mode(32'h0000_0001);
		ticks(3);
		fire(5'h0B);
		rdc("count", OCS_ADDR_COUNT, 32'h0000_FFFF, 32'h0000_0000);
		rdc("trig_stat", OCS_ADDR_CTRL_TWO, 32'h0000_0040, 32'h0000_0040);
		ticks(8);
		rdc("trig_stat", OCS_ADDR_CTRL_TWO, 32'h0000_0040, 32'h0000_0040);
		wr(OCS_ADDR_CTRL_TWO, 32'h0000_008B);
		rdc("trig_stat", OCS_ADDR_CTRL_TWO, 32'h0000_0040, 32'h0000_0000);
		set_mode(32'h0000_0009);
		fire(5'h0B);
		rdc("trig_stat", OCS_ADDR_CTRL_TWO, 32'h0000_0040, 32'h0000_0040);
		ticks(8);
		rdc("trig_stat", OCS_ADDR_CTRL_TWO, 32'h0000_0040, 32'h0000_0000);
		$display("test trigger status done");
		// own secondary match at 6 restarts the count: a period of 7 ticks
		set_mode(32'h0000_0000);
		set_mode(32'h0000_0001);
		wr(OCS_ADDR_CTRL_TWO, 32'h0000_001F);
		ticks(20);
		rdc("count_bound", OCS_ADDR_COUNT, 32'h0000_FFFF, 32'h0000_0006);
		set_mode(32'h0000_0000);
		set_mode(32'h0000_0001);
		exp_cnt = 32'h0000_0000;
		for (int c = 0; c < 31; c++) begin
			wr(OCS_ADDR_CTRL_TWO, 32'(c));
			ticks(1);
			fire(5'(c));
			exp_cnt = src_valid(c) ? 32'h0000_0000 : exp_cnt + 32'h0000_0001;
			rdc("count", OCS_ADDR_COUNT, 32'h0000_FFFF, exp_cnt);
		end
		$display("test source select done");
		close_out();
	end
endmodule // ocs_compare_channel_tb
`default_nettype wire
